// *** core/sfsp_pkg.sv ***
/*
 Constants of the serial flash status and block-protection unit:
 opcodes, status field positions, frame byte counts and busy times.
 Assumes a 100 MHz core clock; all times below are in microseconds.
*/
// What this block does
// - Status read answers on the falling edge of opcode bit eight, no address.
// - Status bits leave most significant first, lock bit down to busy.
// - Continued clocking after bit 0 wraps to bit 7 and repeats.
// - Status read works at any time, even during internal writes.
// - Status write is opcode plus one byte; write starts at chip select rise.
// - Busy and write-enable bits ignore written values without error.
// - Protect size, side, invert and lock bits survive power loss.
// - Status write erases and programs its own nonvolatile bits.
// - Busy reads one during program, erase or status write, else zero.
// - Write enable zero refuses writes; one allows unprotected areas only.
// - Write-enable opcode sets the latch; write-disable opcode clears it; both act only while not busy.
// - Latch clears at power-on and when any erase, program or write ends.
// - Refused or malformed writes and all reads leave the latch unchanged.
// - Size bits pick region size, side bit top or bottom, invert complements.
// - Size code 000 protects nothing whatever side and invert hold.
// - Invert 0, side 0: codes 1 to 4 protect top 1/16 to 1/2.
// - Invert 0, side 1: codes 1 to 4 protect bottom 1/16 to 1/2.
// - Invert 1, side 0: codes 1 to 4 protect bottom 15/16 to 1/2.
// - Invert 1, side 1: codes 1 to 4 protect top 15/16 to 1/2.
// - Code 101 or codes 11x protect the whole array.
// - Chip erase runs only when nothing at all is protected.
// - Lock one with guard pin low ignores status write; guard high allows.
// - Address bits 23 to 20 are ignored, protection compare included.
package sfsp_pkg;
	// Opcodes
	localparam logic [7:0] OP_READ_STATUS  = 8'h05;
	localparam logic [7:0] OP_WRITE_STATUS = 8'h01;
	localparam logic [7:0] OP_WRITE_EN     = 8'h06;
	localparam logic [7:0] OP_WRITE_DIS    = 8'h04;
	localparam logic [7:0] OP_SMALL_ERASE  = 8'h20;
	localparam logic [7:0] OP_SMALL_ERASE2 = 8'hd7;
	localparam logic [7:0] OP_SECTOR_ERASE = 8'hd8;
	localparam logic [7:0] OP_CHIP_ERASE   = 8'h60;
	localparam logic [7:0] OP_CHIP_ERASE2  = 8'hc7;
	localparam logic [7:0] OP_PAGE_PROG    = 8'h02;

	// Status field positions
	localparam int BUSY_POS   = 0;
	localparam int WEN_POS    = 1;
	localparam int SIZE_LSB   = 2;
	localparam int SIDE_POS   = 5;
	localparam int INVERT_POS = 6;
	localparam int LOCK_POS   = 7;
	localparam int NV_LSB     = 2;

	// Reset values
	localparam logic [5:0] NV_RESET     = 6'h00;
	localparam logic [7:0] STATUS_RESET = 8'h00;

	// Frame byte counts, saturating at the page program minimum
	localparam logic [2:0] BYTES_ONE  = 3'h1;
	localparam logic [2:0] BYTES_TWO  = 3'h2;
	localparam logic [2:0] BYTES_ADDR = 3'h4;
	localparam logic [2:0] BYTES_MAX  = 3'h5;

	// Busy times in microseconds and derived cycle counts at 100 MHz
	localparam int CLK_MHZ        = 100;
	localparam int SMALL_ERASE_US = 40000;
	localparam int SECTOR_ERASE_US = 80000;
	localparam int CHIP_ERASE_US  = 500000;
	localparam int PAGE_PROG_US   = 300;
	localparam int STATUS_WR_US   = 5000;
	localparam int SMALL_ERASE_CYC = SMALL_ERASE_US * CLK_MHZ;
	localparam int SECTOR_ERASE_CYC = SECTOR_ERASE_US * CLK_MHZ;
	localparam int CHIP_ERASE_CYC = CHIP_ERASE_US * CLK_MHZ;
	localparam int PAGE_PROG_CYC  = PAGE_PROG_US * CLK_MHZ;
	localparam int STATUS_WR_CYC  = STATUS_WR_US * CLK_MHZ;

	// Internal operation kinds
	typedef enum logic [2:0]
	{
		OPK_NONE,
		OPK_STATUS,
		OPK_SMALL,
		OPK_SECTOR,
		OPK_CHIP,
		OPK_PAGE
	} sfsp_opk_e;
endpackage

// *** core/sfsp_link_if.sv ***
/*
 Carrier between the serial link end and the status core.
 Frame words are written on the serial clock and read by the core only
 after chip select has risen and the serial clock is still.
*/
`timescale 1ns/1ps
`default_nettype none
interface sfsp_link_if;
	logic [7:0]  frm_opcode;  // First byte of the last frame
	logic [7:0]  frm_data;    // Second byte of the last frame
	logic [23:0] frm_addr;    // Bytes two to four of the last frame
	logic [2:0]  frm_bytes;   // Whole bytes seen, saturating
	logic        frm_aligned; // Frame ended on a byte boundary
	logic        frm_toggle;  // Flips once per clocked frame
	logic [7:0]  status;      // Live status word from the core

	modport link (output frm_opcode, frm_data, frm_addr, frm_bytes,
		frm_aligned, frm_toggle, input status);
	modport core (input frm_opcode, frm_data, frm_addr, frm_bytes,
		frm_aligned, frm_toggle, output status);
endinterface
`default_nettype wire

// *** core/sfsp_link.sv ***
/*
 Serial link end, clocked by the host serial clock (modes 0 and 3).
 Samples data on rising edges and shifts status out on falling edges.
 Assumes the serial clock is still while chip select is high.
*/
`timescale 1ns/1ps
`default_nettype none
module sfsp_link
(
	input  wire logic   reset_in,  // Asynchronous cold reset
	input  wire logic   sck_in,    // Host serial clock
	input  wire logic   cs_n_in,   // Chip select, active low
	input  wire logic   si_in,     // Serial data in
	output logic        so_out,    // Serial data out
	output logic        so_oe_n_out, // Data out enable, low drives
	sfsp_link_if.link   lnk        // Frame words and status
);
	logic       frame_rst;
	logic [2:0] bit_cnt;
	logic [2:0] byte_cnt;
	logic [6:0] shift;
	logic [7:0] st_meta;
	logic [7:0] st_sync;
	logic [2:0] out_idx;
	logic       reading;
	wire  [7:0] byte_in  = {shift, si_in};
	wire        byte_end = (bit_cnt == 3'h7);

	// Counters live only within a frame, ended by chip select itself
	assign frame_rst = reset_in | cs_n_in;

	// Bit and byte position within the frame
	always_ff @(posedge sck_in or posedge frame_rst)
	begin
		if (frame_rst)
		begin
			bit_cnt  <= 3'h0;
			byte_cnt <= 3'h0;
			shift    <= 7'h00;
		end
		else
		begin
			bit_cnt <= bit_cnt + 3'h1;
			shift   <= byte_in[6:0];
			if (byte_end && byte_cnt != sfsp_pkg::BYTES_MAX)
				byte_cnt <= byte_cnt + 3'h1;
		end
	end

	// Frame summary survives chip select so the core can read it later
	always_ff @(posedge sck_in or posedge reset_in)
	begin
		if (reset_in)
		begin
			lnk.frm_opcode  <= 8'h00;
			lnk.frm_data    <= 8'h00;
			lnk.frm_addr    <= 24'h000000;
			lnk.frm_bytes   <= 3'h0;
			lnk.frm_aligned <= 1'b0;
			lnk.frm_toggle  <= 1'b0;
		end
		else
		begin
			lnk.frm_aligned <= byte_end;
			if (byte_end && byte_cnt != sfsp_pkg::BYTES_MAX)
				lnk.frm_bytes <= byte_cnt + 3'h1;
			if (bit_cnt == 3'h0 && byte_cnt == 3'h0)
			begin
				lnk.frm_toggle <= ~lnk.frm_toggle;
				lnk.frm_bytes  <= 3'h0;
			end
			if (byte_end && byte_cnt == 3'h0)
				lnk.frm_opcode <= byte_in;
			if (byte_end && byte_cnt == 3'h1)
			begin
				lnk.frm_data        <= byte_in;
				lnk.frm_addr[23:16] <= byte_in;
			end
			if (byte_end && byte_cnt == 3'h2)
				lnk.frm_addr[15:8] <= byte_in;
			if (byte_end && byte_cnt == 3'h3)
				lnk.frm_addr[7:0] <= byte_in;
		end
	end

	// Status word crosses as independent levels through two flops
	always_ff @(posedge sck_in or posedge reset_in)
	begin
		if (reset_in)
		begin
			st_meta <= sfsp_pkg::STATUS_RESET;
			st_sync <= sfsp_pkg::STATUS_RESET;
		end
		else
		begin
			st_meta <= lnk.status;
			st_sync <= st_meta;
		end
	end

	// Opcode is complete on the eighth rising edge, so this falling
	// edge is the first that may answer; no address or dummy bits
	assign reading = (byte_cnt != 3'h0) &&
		(lnk.frm_opcode == sfsp_pkg::OP_READ_STATUS);

	// Falling-edge shifter; idle high-impedance outside status reads
	always_ff @(negedge sck_in or posedge frame_rst)
	begin
		if (frame_rst)
		begin
			so_out      <= 1'b0;
			so_oe_n_out <= 1'b1;
			out_idx     <= 3'h7;
		end
		else if (reading)
		begin
			so_out      <= st_sync[out_idx];
			so_oe_n_out <= 1'b0;
			out_idx     <= out_idx - 3'h1;
		end
	end
endmodule
`default_nettype wire

// *** core/sfsp_top.sv ***
/*
 Status and block-protection unit of an 8 Mbit serial flash.
 Holds the status word, write-enable latch, busy timing and protected
 range check; hands accepted array operations to the array path.
 Assumes the host keeps the serial clock still while chip select is high
 and that chip select stays high for at least four core clock cycles.
*/
`timescale 1ns/1ps
`default_nettype none
module sfsp_top
#(
	parameter int SMALL_ERASE_CYC  = sfsp_pkg::SMALL_ERASE_CYC,
	parameter int SECTOR_ERASE_CYC = sfsp_pkg::SECTOR_ERASE_CYC,
	parameter int CHIP_ERASE_CYC   = sfsp_pkg::CHIP_ERASE_CYC,
	parameter int PAGE_PROG_CYC    = sfsp_pkg::PAGE_PROG_CYC,
	parameter int STATUS_WR_CYC    = sfsp_pkg::STATUS_WR_CYC
)
(
	input  wire logic  clock_in,      // Core clock, 100 MHz
	input  wire logic  reset_in,      // Cold reset, asynchronous
	input  wire logic  power_up_in,   // Power cycle pulse, keeps nv bits
	input  wire logic  sck_in,        // Host serial clock
	input  wire logic  cs_n_in,       // Chip select, active low
	input  wire logic  si_in,         // Serial data in
	input  wire logic  wp_n_in,       // Write guard pin, low guards
	output logic       so_out,        // Serial data out
	output logic       so_oe_n_out,   // Data out enable, low drives
	output logic [7:0] status_out,    // Status word
	output logic       busy_out,      // Internal write running
	output logic       op_start_out,  // Array operation accepted
	output logic [2:0] op_kind_out,   // Kind of accepted operation
	output logic [19:0] op_addr_out,  // Address of accepted operation
	output logic       refused_out    // Write command refused
);
	typedef enum logic [0:0]
	{
		ST_IDLE,
		ST_BUSY
	} sfsp_state_e;

	sfsp_link_if lnk ();

	sfsp_state_e state;
	logic [5:0]  nv_bits;
	logic [5:0]  nv_pending;
	logic        wen;
	logic [31:0] timer;
	logic [2:0]  cur_kind;
	logic        cs_meta;
	logic        cs_sync;
	logic        cs_prev;
	logic        wp_meta;
	logic        wp_sync;
	logic        tog_meta;
	logic        tog_sync;
	logic        tog_seen;

	// Protection test on the 64 KiB sector, address bits above 19 unused
	function automatic logic sfsp_protected(input logic [19:0] addr,
		input logic [5:0] nv);
		logic [2:0] size;
		logic [3:0] sector;
		logic [4:0] span;
		logic       region;
		size   = nv[2:0];
		sector = addr[19:16];
		span   = 5'h01 << (size - 3'h1);
		region = nv[3] ? ({1'b0, sector} < span)
			: ({1'b0, sector} >= (5'h10 - span));
		if (size == 3'h0)
			sfsp_protected = 1'b0;
		else if (size >= 3'h5)
			sfsp_protected = 1'b1;
		else
			sfsp_protected = nv[4] ? ~region : region;
	endfunction

	// Link end on the serial clock
	sfsp_link u_link
	(
		.reset_in    (reset_in),
		.sck_in      (sck_in),
		.cs_n_in     (cs_n_in),
		.si_in       (si_in),
		.so_out      (so_out),
		.so_oe_n_out (so_oe_n_out),
		.lnk         (lnk)
	);

	// Pins and the frame toggle pass two flops before use
	always_ff @(posedge clock_in or posedge reset_in)
	begin
		if (reset_in)
		begin
			cs_meta  <= 1'b1;
			cs_sync  <= 1'b1;
			cs_prev  <= 1'b1;
			// Idle level of the guard pin, so no false guard after reset
			wp_meta  <= 1'b1;
			wp_sync  <= 1'b1;
			tog_meta <= 1'b0;
			tog_sync <= 1'b0;
		end
		else
		begin
			cs_meta  <= cs_n_in;
			cs_sync  <= cs_meta;
			cs_prev  <= cs_sync;
			wp_meta  <= wp_n_in;
			wp_sync  <= wp_meta;
			tog_meta <= lnk.frm_toggle;
			tog_sync <= tog_meta;
		end
	end

	// Decode of a finished frame; the toggle screens out empty frames
	wire frame_end = cs_sync & ~cs_prev & (tog_sync != tog_seen);
	wire idle      = (state == ST_IDLE);
	wire aligned   = lnk.frm_aligned;
	wire [7:0] opc = lnk.frm_opcode;
	wire [2:0] nby = lnk.frm_bytes;
	wire [19:0] adr = lnk.frm_addr[19:0];
	wire addr_prot = sfsp_protected(adr, nv_bits);
	wire lock_held = nv_bits[5] & ~wp_sync;

	wire is_wen  = (opc == sfsp_pkg::OP_WRITE_EN) && aligned &&
		(nby == sfsp_pkg::BYTES_ONE);
	wire is_wdis = (opc == sfsp_pkg::OP_WRITE_DIS) && aligned &&
		(nby == sfsp_pkg::BYTES_ONE);
	wire is_wrsr = (opc == sfsp_pkg::OP_WRITE_STATUS) && aligned &&
		(nby == sfsp_pkg::BYTES_TWO);
	wire is_small = ((opc == sfsp_pkg::OP_SMALL_ERASE) ||
		(opc == sfsp_pkg::OP_SMALL_ERASE2)) && aligned &&
		(nby == sfsp_pkg::BYTES_ADDR);
	wire is_sector = (opc == sfsp_pkg::OP_SECTOR_ERASE) && aligned &&
		(nby == sfsp_pkg::BYTES_ADDR);
	wire is_chip = ((opc == sfsp_pkg::OP_CHIP_ERASE) ||
		(opc == sfsp_pkg::OP_CHIP_ERASE2)) && aligned &&
		(nby == sfsp_pkg::BYTES_ONE);
	wire is_page = (opc == sfsp_pkg::OP_PAGE_PROG) && aligned &&
		(nby == sfsp_pkg::BYTES_MAX);
	wire is_write = (opc == sfsp_pkg::OP_WRITE_STATUS) ||
		(opc == sfsp_pkg::OP_SMALL_ERASE) ||
		(opc == sfsp_pkg::OP_SMALL_ERASE2) ||
		(opc == sfsp_pkg::OP_SECTOR_ERASE) ||
		(opc == sfsp_pkg::OP_CHIP_ERASE) ||
		(opc == sfsp_pkg::OP_CHIP_ERASE2) ||
		(opc == sfsp_pkg::OP_PAGE_PROG);

	// Acceptance: latch set, unprotected target, idle core
	wire ok_wrsr  = is_wrsr & wen & ~lock_held;
	wire ok_addr  = (is_small | is_sector | is_page) & wen &
		~addr_prot;
	wire ok_chip  = is_chip & wen &
		(nv_bits[2:0] == 3'h0);
	wire accept   = frame_end & idle & (ok_wrsr | ok_addr | ok_chip);
	wire refuse   = frame_end & is_write & ~(idle &
		(ok_wrsr | ok_addr | ok_chip));
	wire done     = (state == ST_BUSY) && (timer == 32'h0);

	// Kind and busy length of the accepted operation
	wire [2:0] next_kind =
		ok_wrsr   ? 3'(sfsp_pkg::OPK_STATUS) :
		is_small  ? 3'(sfsp_pkg::OPK_SMALL)  :
		is_sector ? 3'(sfsp_pkg::OPK_SECTOR) :
		is_chip   ? 3'(sfsp_pkg::OPK_CHIP)   :
		3'(sfsp_pkg::OPK_PAGE);
	wire [31:0] next_timer =
		ok_wrsr   ? 32'(STATUS_WR_CYC - 1)    :
		is_small  ? 32'(SMALL_ERASE_CYC - 1)  :
		is_sector ? 32'(SECTOR_ERASE_CYC - 1) :
		is_chip   ? 32'(CHIP_ERASE_CYC - 1)   :
		32'(PAGE_PROG_CYC - 1);

	// Busy sequencing; a status write erases and reprograms its own
	// cells internally, so the new bits land only when it ends
	always_ff @(posedge clock_in or posedge reset_in)
	begin
		if (reset_in)
		begin
			state      <= ST_IDLE;
			timer      <= 32'h0;
			cur_kind   <= 3'(sfsp_pkg::OPK_NONE);
			nv_pending <= sfsp_pkg::NV_RESET;
			tog_seen   <= 1'b0;
		end
		else
		begin
			if (cs_sync & ~cs_prev)
				tog_seen <= tog_sync;
			case (state)
				ST_IDLE:
				begin
					if (power_up_in)
						state <= ST_IDLE;
					else if (accept)
					begin
						state      <= ST_BUSY;
						timer      <= next_timer;
						cur_kind   <= next_kind;
						nv_pending <= lnk.frm_data[7:2];
					end
				end
				ST_BUSY:
				begin
					if (power_up_in)
						state <= ST_IDLE;
					else if (timer == 32'h0)
						state <= ST_IDLE;
					else
						timer <= timer - 32'h1;
				end
				default:
					state <= ST_IDLE;
			endcase
		end
	end

	// Nonvolatile bits; a power cycle does not touch them, only the
	// cold reset that stands for factory state
	always_ff @(posedge clock_in or posedge reset_in)
	begin
		if (reset_in)
			nv_bits <= sfsp_pkg::NV_RESET;
		else if (done && !power_up_in &&
			cur_kind == 3'(sfsp_pkg::OPK_STATUS))
			nv_bits <= nv_pending;
	end

	// Write-enable latch; refused frames and reads leave it alone
	always_ff @(posedge clock_in or posedge reset_in)
	begin
		if (reset_in)
			wen <= 1'b0;
		else if (power_up_in || done)
			wen <= 1'b0;
		else if (frame_end && idle && is_wen)
			wen <= 1'b1;
		else if (frame_end && idle && is_wdis)
			wen <= 1'b0;
	end

	// Status word for the link and the pins
	assign lnk.status = {nv_bits, wen, (state == ST_BUSY)};

	// Registered outputs toward the array path
	always_ff @(posedge clock_in or posedge reset_in)
	begin
		if (reset_in)
		begin
			status_out   <= sfsp_pkg::STATUS_RESET;
			busy_out     <= 1'b0;
			op_start_out <= 1'b0;
			op_kind_out  <= 3'(sfsp_pkg::OPK_NONE);
			op_addr_out  <= 20'h00000;
			refused_out  <= 1'b0;
		end
		else
		begin
			status_out   <= lnk.status;
			busy_out     <= (state == ST_BUSY);
			op_start_out <= accept && !power_up_in;
			refused_out  <= refuse;
			if (accept)
			begin
				op_kind_out <= next_kind;
				op_addr_out <= adr;
			end
		end
	end
endmodule
`default_nettype wire

// *** tb/sfsp_top_props.sv ***
/*
 Checker for the status and protection unit, bound to sfsp_top.
 Assumes only the top-level ports and the busy-time parameters.
*/
`timescale 1ns/1ps
`default_nettype none
module sfsp_top_props
#(
	parameter int SMALL_ERASE_CYC  = 40,
	parameter int SECTOR_ERASE_CYC = 40,
	parameter int CHIP_ERASE_CYC   = 60,
	parameter int PAGE_PROG_CYC    = 30,
	parameter int STATUS_WR_CYC    = 200
)
(
	input wire logic       clock_in,     // Core clock
	input wire logic       reset_in,     // Cold reset
	input wire logic       power_up_in,  // Power cycle pulse
	input wire logic       cs_n_in,      // Chip select
	input wire logic       so_oe_n_out,  // Data out enable
	input wire logic [7:0] status_out,   // Status word
	input wire logic       busy_out,     // Busy level
	input wire logic       op_start_out, // Accepted operation
	input wire logic [2:0] op_kind_out,  // Operation kind
	input wire logic       refused_out   // Refused frame
);
	int busy_len;
	int exp_len;

	// Length of the running busy stretch
	always_ff @(posedge clock_in or posedge reset_in)
	begin
		if (reset_in)
			busy_len <= 0;
		else
			busy_len <= busy_out ? busy_len + 1 : 0;
	end

	// Busy length owed by the kind last accepted
	assign exp_len = (op_kind_out == 3'h1) ? STATUS_WR_CYC :
		(op_kind_out == 3'h2) ? SMALL_ERASE_CYC :
		(op_kind_out == 3'h3) ? SECTOR_ERASE_CYC :
		(op_kind_out == 3'h4) ? CHIP_ERASE_CYC : PAGE_PROG_CYC;

	default clocking dclk @(posedge clock_in); endclocking
	default disable iff (reset_in);

	one_outcome_a:
	assert property (!(op_start_out && refused_out))
		else $error("start and refusal together");
	start_needs_wen_a:
	assert property (op_start_out |-> $past(status_out[1]) && !$past(busy_out))
		else $error("start without latch or while busy");
	start_busy_a:
	assert property (op_start_out |-> ##[0:1] busy_out)
		else $error("accepted operation not busy");
	busy_time_a:
	assert property ($fell(busy_out) && !$past(power_up_in)
		&& !$past(power_up_in, 2) |-> busy_len == exp_len)
		else $error("busy length wrong");
	busy_flag_a:
	assert property ($rose(busy_out) |-> ##[0:1] status_out[0])
		else $error("busy bit not shown");
	end_clears_wen_a:
	assert property ($fell(busy_out) |-> ##[0:1] !status_out[1])
		else $error("latch kept after completion");
	refuse_keeps_wen_a:
	assert property (refused_out |-> ##1 $stable(status_out[1]) [*3])
		else $error("refusal changed latch");
	chip_erase_level_a:
	assert property (op_start_out && op_kind_out == 3'h4
		|-> status_out[4:2] == 3'h0)
		else $error("chip erase while protected");
	nv_steady_a:
	assert property (!busy_out && !$past(busy_out) && !$past(busy_out, 2)
		&& !$past(busy_out, 3) |-> $stable(status_out[7:2]))
		else $error("stored bits moved while idle");
	oe_idle_a:
	assert property (cs_n_in && $past(cs_n_in) |-> so_oe_n_out)
		else $error("data out driven while deselected");
endmodule
`default_nettype wire

// *** tb/sfsp_host_model.sv ***
/*
 Serial host model: frames commands in mode 0 at a 32 ns clock.
 Assumes callers leave it idle between frames; the clock stays still
 outside frames, and data in is flipped once the frame is over.
*/
`timescale 1ns/1ps
`default_nettype none
module sfsp_host_model
(
	output logic      sck_out,    // Serial clock, still when idle
	output logic      cs_n_out,   // Chip select
	output logic      si_out,     // Serial data to device
	input wire logic  so_in,      // Serial data from device
	input wire logic  so_oe_n_in  // Device drives when low
);
	initial
	begin
		sck_out = 1'b0;
		cs_n_out = 1'b1;
		si_out = 1'b0;
	end

	// Shift nb bits MSB first; bits after the opcode are captured
	task automatic xfer(input logic [39:0] tx, input int nb,
		output logic [15:0] rx);
		int i;
		rx = 16'h0000;
		#3;
		cs_n_out = 1'b0;
		for (i = 0; i < nb; i++)
		begin
			si_out = tx[39 - i];
			#16;
			sck_out = 1'b1;
			if (i >= 8)
				rx = {rx[14:0], so_oe_n_in ? 1'bx : so_in};
			#16;
			sck_out = 1'b0;
		end
		#16;
		cs_n_out = 1'b1;
		si_out = ~si_out;
		// Deselect gap well over four core cycles
		#60;
	endtask

	// Poll busy through status reads, bounded
	task automatic wait_ready(output logic ok);
		logic [15:0] r;
		int k;
		ok = 1'b0;
		for (k = 0; k < 40 && !ok; k++)
		begin
			xfer(40'h05_0000_0000, 16, r);
			ok = (r[0] === 1'b0);
		end
	endtask
endmodule
`default_nettype wire

// *** tb/test_spi_flash_status_protect.sv ***
/*
 Testbench of the status and protection unit: a table of protection
 cases, then hand tests. Assumes the host model drives the link.
*/
`timescale 1ns/1ps
`default_nettype none
module test_spi_flash_status_protect;
	typedef struct packed {
		logic [7:0]  nv;
		logic [23:0] addr;
		logic        refd;
	} sfsp_row_s;
	localparam logic [39:0] RD = 40'h05_0000_0000;
	logic        clock_in = 1'b0;
	logic        reset_in = 1'b1;
	logic        power_up_in = 1'b0;
	logic        wp_n_in = 1'b1;
	logic        sck, cs_n, si, so, so_oe_n, busy, op_start, refused;
	logic [7:0]  status;
	logic [2:0]  op_kind;
	logic [19:0] op_addr;
	logic        saw_st, saw_rf;
	logic [15:0] rx;
	int          n_fail = 0;
	int          n_compared = 0;
	logic [7:0]  ops [6] = '{8'h20, 8'hd7, 8'hd8, 8'h60, 8'hc7, 8'h02};
	logic [2:0]  kinds [6] = '{3'h2, 3'h2, 3'h3, 3'h4, 3'h4, 3'h5};
	int          nbs [6] = '{32, 32, 32, 8, 8, 40};
	sfsp_row_s   rows [18] = '{
		{8'h60, 24'h000000, 1'b0}, {8'h04, 24'hff0000, 1'b1},
		{8'h04, 24'haeffff, 1'b0}, {8'h10, 24'h080000, 1'b1},
		{8'h10, 24'h07ffff, 1'b0}, {8'h24, 24'h00ffff, 1'b1},
		{8'h24, 24'h010000, 1'b0}, {8'h2c, 24'h03ffff, 1'b1},
		{8'h2c, 24'h040000, 1'b0}, {8'h44, 24'h0effff, 1'b1},
		{8'h44, 24'h0f0000, 1'b0}, {8'h4c, 24'h0bffff, 1'b1},
		{8'h4c, 24'h0c0000, 1'b0}, {8'h68, 24'h020000, 1'b1},
		{8'h68, 24'h01ffff, 1'b0}, {8'h14, 24'h000000, 1'b1},
		{8'h18, 24'h0fffff, 1'b1}, {8'h7c, 24'h070000, 1'b1}};

	always #5 clock_in = ~clock_in;

	sfsp_top #(.SMALL_ERASE_CYC(40), .SECTOR_ERASE_CYC(40),
		.CHIP_ERASE_CYC(60), .PAGE_PROG_CYC(30), .STATUS_WR_CYC(200))
	i_dut (.clock_in(clock_in), .reset_in(reset_in),
		.power_up_in(power_up_in), .sck_in(sck), .cs_n_in(cs_n),
		.si_in(si), .wp_n_in(wp_n_in), .so_out(so),
		.so_oe_n_out(so_oe_n), .status_out(status), .busy_out(busy),
		.op_start_out(op_start), .op_kind_out(op_kind),
		.op_addr_out(op_addr), .refused_out(refused));

	sfsp_host_model i_host (.sck_out(sck), .cs_n_out(cs_n), .si_out(si),
		.so_in(so), .so_oe_n_in(so_oe_n));

	// Latch the one-cycle outcome pulses of each frame
	always @(posedge clock_in)
	begin
		if (op_start === 1'b1)
			saw_st = 1'b1;
		if (refused === 1'b1)
			saw_rf = 1'b1;
	end

	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			n_fail++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic end_sim();
		$display("compared %0d, mismatches %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic frame(input logic [39:0] tx, input int nb);
		saw_st = 1'b0;
		saw_rf = 1'b0;
		i_host.xfer(tx, nb, rx);
		repeat (8) @(posedge clock_in);
	endtask

	task automatic ready();
		logic ok;
		i_host.wait_ready(ok);
		repeat (4) @(posedge clock_in);
		chk(24'(ok), 24'h1);
	endtask

	task automatic wren();
		frame(40'h06_0000_0000, 8);
	endtask

	task automatic wrst(input logic [7:0] d);
		wren();
		frame({8'h01, d, 24'h0}, 16);
		ready();
	endtask

	initial
	begin
		repeat (4) @(posedge clock_in);
		reset_in <= 1'b0;
		repeat (3) @(posedge clock_in);
		// Protection table; written low bits must not stick
		foreach (rows[r])
		begin
			wrst(rows[r].nv | 8'h03);
			chk(24'(status), {16'h0, rows[r].nv[7:2], 2'b00});
			wren();
			frame({8'hd8, rows[r].addr, 8'h00}, 32);
			chk(24'({saw_st, saw_rf}), 24'({~rows[r].refd, rows[r].refd}));
			chk(24'(status[1]), 24'h1);
			if (!rows[r].refd)
				chk(24'({op_kind, op_addr}), {1'b0, 3'h3, rows[r].addr[19:0]});
			ready();
		end
		// Latch set, cleared, and status write refused without it
		wren();
		chk(24'(status[1]), 24'h1);
		frame(40'h04_0000_0000, 8);
		chk(24'(status[1]), 24'h0);
		frame(40'h01_0000_0000, 16);
		chk(24'({saw_st, saw_rf}), 24'h1);
		// Read during a running status write: old bits, busy, wrap
		wren();
		frame(40'h01_0800_0000, 16);
		chk(24'(busy), 24'h1);
		i_host.xfer(RD, 24, rx);
		chk(24'(rx), 24'h7f7f);
		ready();
		chk(24'(status), 24'h08);
		// Chip erase while protected, malformed write, then a read
		wren();
		frame(40'h60_0000_0000, 8);
		chk(24'({saw_st, saw_rf, status[1]}), 24'h3);
		frame(40'h01_0000_0000, 24);
		chk(24'({saw_st, saw_rf, status[1]}), 24'h3);
		i_host.xfer(RD, 24, rx);
		chk(24'(rx[7:0]), 24'h0a);
		// Every erase and program opcode with nothing protected
		wrst(8'h00);
		foreach (ops[k])
		begin
			wren();
			frame({ops[k], 32'h0001_2345}, nbs[k]);
			chk(24'({saw_st, saw_rf, op_kind}), {19'h0, 2'b10, kinds[k]});
			ready();
			chk(24'(status), 24'h0);
		end
		// Lock bit with the guard pin low, then high
		wrst(8'h80);
		@(posedge clock_in) wp_n_in <= 1'b0;
		wren();
		frame(40'h01_0000_0000, 16);
		chk(24'({saw_rf, status}), 24'h182);
		@(posedge clock_in) wp_n_in <= 1'b1;
		wrst(8'h00);
		chk(24'(status), 24'h0);
		// Power cycle keeps stored bits and drops the latch
		wrst(8'h2c);
		wren();
		@(posedge clock_in) power_up_in <= 1'b1;
		@(posedge clock_in) power_up_in <= 1'b0;
		repeat (4) @(posedge clock_in);
		chk(24'(status), 24'h2c);
		// Reset in the middle of an erase
		wren();
		frame(40'hd8_0f00_0000, 32);
		@(posedge clock_in) reset_in <= 1'b1;
		repeat (4) @(posedge clock_in);
		reset_in <= 1'b0;
		@(posedge clock_in);
		chk(24'({status, busy, so_oe_n}), 24'h001);
		end_sim();
	end

	// Watchdog well beyond the expected run length
	initial
	begin
		#800000;
		n_fail++;
		end_sim();
	end
endmodule

bind sfsp_top sfsp_top_props #(.SMALL_ERASE_CYC(SMALL_ERASE_CYC),
	.SECTOR_ERASE_CYC(SECTOR_ERASE_CYC), .CHIP_ERASE_CYC(CHIP_ERASE_CYC),
	.PAGE_PROG_CYC(PAGE_PROG_CYC), .STATUS_WR_CYC(STATUS_WR_CYC))
i_props (.clock_in(clock_in), .reset_in(reset_in),
	.power_up_in(power_up_in), .cs_n_in(cs_n_in),
	.so_oe_n_out(so_oe_n_out), .status_out(status_out),
	.busy_out(busy_out), .op_start_out(op_start_out),
	.op_kind_out(op_kind_out), .refused_out(refused_out));
`default_nettype wire
